//--- design/mbd_top.sv
// Purpose: channel allocation and ping/pong block DMA descriptor handling
// Assumes: one clock, inputs synchronous to clk_i; memory mover handshakes on req/ack
// Notes:   the table sits in flip-flops and is only reachable indirectly
`default_nettype none
// Notes on behaviour
// - channel type codes: sync 000, control 001, async 010, isochronous 011.
// - transmit: block DMA inbound; receive: block DMA outbound.
// - channels 0 to 63, each programmed separately.
// - descriptor table reachable only via memory interface registers.
// - page holds 32-bit base and 11-bit depth, bytes minus one.
// - three-bit frames per sub-buffer field in configuration register.
module mbd_top
  import mbd_pkg::*;
#(
  parameter int NUM_CH = 64
) (
  input  wire logic                clk_i,
  input  wire logic                rst_n_i,
  input  wire logic                s_axi_awvalid_i,
  output logic                     s_axi_awready_o,
  input  wire logic [7:0]          s_axi_awaddr_i,
  input  wire logic                s_axi_wvalid_i,
  output logic                     s_axi_wready_o,
  input  wire logic [31:0]         s_axi_wdata_i,
  input  wire logic [3:0]          s_axi_wstrb_i,
  output logic                     s_axi_bvalid_o,
  input  wire logic                s_axi_bready_i,
  output logic [1:0]               s_axi_bresp_o,
  input  wire logic                s_axi_arvalid_i,
  output logic                     s_axi_arready_o,
  input  wire logic [7:0]          s_axi_araddr_i,
  output logic                     s_axi_rvalid_o,
  input  wire logic                s_axi_rready_i,
  output logic [31:0]              s_axi_rdata_o,
  output logic [1:0]               s_axi_rresp_o,
  output logic                     dma_req_o,
  input  wire logic                dma_ack_i,
  input  wire logic                dma_err_i,
  output logic [31:0]              dma_addr_o,
  output logic [11:0]              dma_len_o,
  output logic                     dma_mem_read_o,
  output logic                     dma_pkt_start_o,
  output logic [2:0]               dma_chan_type_o,
  output logic [5:0]               dma_chan_o,
  output logic [2:0]               frames_per_subbuf_o,
  output logic                     irq_o
);
  import mbd_pkg::*;
  localparam int IDX_W = $clog2(NUM_CH) + 2;

  // register state
  logic [31:0]      tbl_r [0:NUM_CH*4-1];
  logic [31:0]      cfg_r;
  logic [IDX_W-1:0] mif_addr_r;
  logic [63:0]      txmap_r;
  logic [MBD_ST_W-1:0] status_r, irq_en_r;
  logic             aw_have_r, w_have_r;
  logic [7:0]       aw_addr_r;
  logic [31:0]      w_data_r;
  logic [3:0]       w_strb_r;
  mbd_eng_t         eng_r;
  logic [5:0]       ch_r;

  // write path: address and data may arrive in either order
  wire        wr_go    = aw_have_r && w_have_r && !s_axi_bvalid_o;
  wire        wr_full  = (w_strb_r == 4'hF);
  wire        wr_cfg   = wr_go && (aw_addr_r == MBD_CFG_OFS);
  wire        wr_maddr = wr_go && (aw_addr_r == MBD_MIF_ADDR_OFS);
  wire        wr_mdata = wr_go && (aw_addr_r == MBD_MIF_DATA_OFS) && wr_full;
  wire        wr_clr   = wr_go && (aw_addr_r == MBD_IRQ_CLR_OFS);
  wire        wr_en    = wr_go && (aw_addr_r == MBD_IRQ_EN_OFS);
  wire        wr_txlo  = wr_go && (aw_addr_r == MBD_TXMAP_LO_OFS);
  wire        wr_txhi  = wr_go && (aw_addr_r == MBD_TXMAP_HI_OFS);
  wire        wr_hit   = wr_cfg || wr_maddr || wr_mdata || wr_clr || wr_en || wr_txlo ||
                         wr_txhi;
  assign s_axi_awready_o = !aw_have_r;
  assign s_axi_wready_o  = !w_have_r;

  // engine view of the current channel
  wire [IDX_W-1:0] ch_base  = {ch_r[IDX_W-3:0], 2'b00};
  wire [31:0] cat_w   = tbl_r[ch_base | IDX_W'(MBD_W_ALLOC)];
  wire [31:0] ctrl_w  = tbl_r[ch_base | IDX_W'(MBD_W_CTRL)];
  wire        page    = ctrl_w[MBD_CUR_PAGE_BIT];
  wire [15:0] pg_w    = page ? ctrl_w[31:16] : ctrl_w[15:0];
  wire [31:0] base_w  = tbl_r[ch_base | (page ? IDX_W'(MBD_W_PONG_BASE)
                                              : IDX_W'(MBD_W_PING_BASE))];
  wire [2:0]  ct_in   = cat_w[MBD_CAT_TYPE_LSB +: 3];
  wire [2:0]  ct_out  = cat_w[MBD_OUT_ENTRY_LSB + MBD_CAT_TYPE_LSB +: 3];
  // both entries must be enabled before the channel moves data
  wire        ch_live = cat_w[MBD_CAT_EN_BIT] && cat_w[MBD_OUT_ENTRY_LSB + MBD_CAT_EN_BIT];
  wire        type_ok = (ct_in <= MBD_CT_ISOC) && (ct_in == ct_out);
  wire        svc     = (eng_r == MBD_ENG_SCAN) && cfg_r[MBD_CFG_EN_BIT] && ch_live &&
                        pg_w[MBD_PG_RDY_BIT] && !pg_w[MBD_PG_DONE_BIT];
  wire        issue   = svc && type_ok;
  wire        bad_svc = svc && !type_ok;
  wire        fin_ok  = (eng_r == MBD_ENG_BUSY) && dma_ack_i;
  wire        eng_we  = fin_ok || bad_svc;
  wire        eng_err = bad_svc || dma_err_i;
  wire [IDX_W-1:0] ctrl_idx = ch_base | IDX_W'(MBD_W_CTRL);

  // completion: set done (and error on failure), drop ready, flip to other page; merges a same-cycle
  // software write so neither the hardware set nor the software data is lost
  logic [31:0] ctrl_src, ctrl_nxt;
  logic [15:0] pg_nxt;
  always_comb begin
    ctrl_src = (wr_mdata && mif_addr_r == ctrl_idx) ? w_data_r : ctrl_w;
    pg_nxt   = page ? ctrl_src[31:16] : ctrl_src[15:0];
    pg_nxt[MBD_PG_DONE_BIT] = 1'b1;
    pg_nxt[MBD_PG_ERR_BIT]  = eng_err;
    pg_nxt[MBD_PG_RDY_BIT]  = 1'b0;
    ctrl_nxt = ctrl_src;
    if (page) begin
      ctrl_nxt[31:16] = pg_nxt;
    end else begin
      ctrl_nxt[15:0] = pg_nxt;
    end
    ctrl_nxt[MBD_CUR_PAGE_BIT] = !page;
  end

  // table storage; written by the memory interface registers and by the engine on completion
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NUM_CH*4; i++) begin
        tbl_r[i] <= 32'h0000_0000;
      end
    end else begin
      if (wr_mdata) begin
        tbl_r[mif_addr_r] <= w_data_r;
      end
      if (eng_we) begin
        tbl_r[ctrl_idx] <= ctrl_nxt;
      end
    end
  end

  // axi write side and control registers
  wire [MBD_ST_W-1:0] ev = {eng_we && eng_err, eng_we && !eng_err};
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= MBD_RESP_OKAY;
      cfg_r      <= MBD_CFG_RST;
      mif_addr_r <= '0;
      txmap_r    <= 64'h0;
      irq_en_r   <= '0;
      status_r   <= '0;
    end else begin
      if (s_axi_awvalid_i && !aw_have_r) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && !w_have_r) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata_i;
        w_strb_r <= s_axi_wstrb_i;
      end
      if (wr_go) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_hit ? MBD_RESP_OKAY : MBD_RESP_SLVERR;
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
      end
      if (wr_cfg) cfg_r <= w_data_r;
      if (wr_maddr) mif_addr_r <= w_data_r[IDX_W-1:0];
      if (wr_en) irq_en_r <= w_data_r[MBD_ST_W-1:0];
      if (wr_txlo) txmap_r[31:0] <= w_data_r;
      if (wr_txhi) txmap_r[63:32] <= w_data_r;
      // a new event in the clearing cycle survives
      status_r <= (status_r & ~(wr_clr ? w_data_r[MBD_ST_W-1:0] : '0)) | ev;
    end
  end

  // read side: one cycle after the address is taken
  wire [7:0] ra = s_axi_araddr_i;
  wire       rd_hit = (ra == MBD_CFG_OFS) || (ra == MBD_MIF_ADDR_OFS) ||
                      (ra == MBD_MIF_DATA_OFS) || (ra == MBD_STATUS_OFS) ||
                      (ra == MBD_IRQ_CLR_OFS) || (ra == MBD_IRQ_EN_OFS) ||
                      (ra == MBD_TXMAP_LO_OFS) || (ra == MBD_TXMAP_HI_OFS) ||
                      (ra == MBD_ENGINE_OFS);
  wire [31:0] rd_val =
    (ra == MBD_CFG_OFS)      ? cfg_r :
    (ra == MBD_MIF_ADDR_OFS) ? 32'(mif_addr_r) :
    (ra == MBD_MIF_DATA_OFS) ? tbl_r[mif_addr_r] :
    (ra == MBD_STATUS_OFS)   ? 32'(status_r) :
    (ra == MBD_IRQ_EN_OFS)   ? 32'(irq_en_r) :
    (ra == MBD_TXMAP_LO_OFS) ? txmap_r[31:0] :
    (ra == MBD_TXMAP_HI_OFS) ? txmap_r[63:32] :
    (ra == MBD_ENGINE_OFS)   ? {23'h0, (eng_r == MBD_ENG_BUSY), 2'h0, ch_r} : 32'h0;
  assign s_axi_arready_o = !s_axi_rvalid_o;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h0000_0000;
      s_axi_rresp_o  <= MBD_RESP_OKAY;
    end else if (s_axi_arvalid_i && !s_axi_rvalid_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o  <= rd_val;
      s_axi_rresp_o  <= rd_hit ? MBD_RESP_OKAY : MBD_RESP_SLVERR;
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // engine: round-robin over channels 0..NUM_CH-1, one page transfer at a time
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      eng_r <= MBD_ENG_SCAN;
      ch_r  <= 6'h00;
      dma_addr_o      <= 32'h0000_0000;
      dma_len_o       <= 12'h000;
      dma_mem_read_o  <= 1'b0;
      dma_pkt_start_o <= 1'b0;
      dma_chan_type_o <= 3'h0;
      dma_chan_o      <= 6'h00;
    end else begin
      case (eng_r)
        MBD_ENG_SCAN: begin
          if (issue) begin
            eng_r <= MBD_ENG_BUSY;
            dma_addr_o      <= base_w;
            dma_len_o       <= 12'(pg_w[MBD_PG_DEPTH_LSB +: 11]) + 12'h001;
            dma_mem_read_o  <= txmap_r[ch_r];
            dma_pkt_start_o <= pg_w[MBD_PG_PS_BIT];
            dma_chan_type_o <= ct_in;
            dma_chan_o      <= ch_r;
          end else begin
            ch_r <= (ch_r == 6'(NUM_CH - 1)) ? 6'h00 : ch_r + 6'h01;
          end
        end
        MBD_ENG_BUSY: begin
          if (dma_ack_i) begin
            eng_r <= MBD_ENG_SCAN;
            ch_r  <= (ch_r == 6'(NUM_CH - 1)) ? 6'h00 : ch_r + 6'h01;
          end
        end
        default: eng_r <= MBD_ENG_SCAN;
      endcase
    end
  end

  // request is a level held until the mover acknowledges
  assign dma_req_o           = (eng_r == MBD_ENG_BUSY);
  assign frames_per_subbuf_o = cfg_r[MBD_CFG_FPS_LSB +: 3];
  assign irq_o               = |(status_r & irq_en_r);

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_req_held:    assert property (dma_req_o && !dma_ack_i |=>
                   dma_req_o && $stable(dma_addr_o)) else $error("request dropped before ack");
  a_done_set:    assert property (fin_ok && !dma_err_i |=> status_r[MBD_ST_DONE])
                   else $error("done status missing");
  a_err_set:     assert property (fin_ok && dma_err_i |=> status_r[MBD_ST_ERR])
                   else $error("error status missing");
  a_page_flip:   assert property (eng_we && !(wr_mdata && mif_addr_r == ctrl_idx) |=>
                   tbl_r[$past(ctrl_idx)][MBD_CUR_PAGE_BIT] != $past(page))
                   else $error("page did not switch");
  a_type_gate:   assert property (issue |=> dma_chan_type_o <= MBD_CT_ISOC)
                   else $error("bad channel type issued");
  a_dir_map:     assert property (issue |=> dma_mem_read_o == $past(txmap_r[ch_r]))
                   else $error("direction mismatch");
  a_len_depth:   assert property (issue |=> dma_len_o ==
                   12'($past(pg_w[10:0])) + 12'h001) else $error("length not depth plus one");
  a_mif_write:   assert property (wr_mdata && !eng_we |=>
                   tbl_r[$past(mif_addr_r)] == $past(w_data_r)) else $error("table write lost");
  a_irq_level:   assert property ((ev & irq_en_r) != '0 && !wr_en |=> irq_o)
                   else $error("enabled event did not raise irq");
  a_ch_range:    assert property (dma_req_o |-> dma_chan_o <= 6'(NUM_CH - 1))
                   else $error("channel out of range");
  c_transfer:    cover property (issue ##[1:20] fin_ok);
  c_bad_type:    cover property (bad_svc);
  c_pong_served: cover property (issue && page);
endmodule : mbd_top
`default_nettype wire

//--- design/mbd_pkg.sv
// Purpose: shared constants for the media bus channel DMA setup block
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes:   channel table words are reached only through the memory interface registers
`default_nettype none
package mbd_pkg;
  // register byte offsets
  localparam logic [7:0] MBD_CFG_OFS      = 8'h00;
  localparam logic [7:0] MBD_MIF_ADDR_OFS = 8'h04;
  localparam logic [7:0] MBD_MIF_DATA_OFS = 8'h08;
  localparam logic [7:0] MBD_STATUS_OFS   = 8'h0C;
  localparam logic [7:0] MBD_IRQ_CLR_OFS  = 8'h10;
  localparam logic [7:0] MBD_IRQ_EN_OFS   = 8'h14;
  localparam logic [7:0] MBD_TXMAP_LO_OFS = 8'h18;
  localparam logic [7:0] MBD_TXMAP_HI_OFS = 8'h1C;
  localparam logic [7:0] MBD_ENGINE_OFS   = 8'h20;
  // table word index within a channel
  localparam logic [1:0] MBD_W_ALLOC      = 2'h0;
  localparam logic [1:0] MBD_W_PING_BASE  = 2'h1;
  localparam logic [1:0] MBD_W_PONG_BASE  = 2'h2;
  localparam logic [1:0] MBD_W_CTRL       = 2'h3;
  // allocation entry fields (inbound entry in [15:0], outbound in [31:16])
  localparam int MBD_CAT_LABEL_LSB  = 0;
  localparam int MBD_CAT_TYPE_LSB   = 6;
  localparam int MBD_CAT_DIR_BIT    = 9;
  localparam int MBD_CAT_MUTE_BIT   = 10;
  localparam int MBD_CAT_EN_BIT     = 11;
  localparam int MBD_OUT_ENTRY_LSB  = 16;
  // page fields inside each half of the control word
  localparam int MBD_PG_DEPTH_LSB   = 0;
  localparam int MBD_PG_PS_BIT      = 11;
  localparam int MBD_PG_DONE_BIT    = 12;
  localparam int MBD_PG_ERR_BIT     = 13;
  localparam int MBD_PG_RDY_BIT     = 14;
  localparam int MBD_CUR_PAGE_BIT   = 31;
  // channel types
  localparam logic [2:0] MBD_CT_SYNC  = 3'h0;
  localparam logic [2:0] MBD_CT_CTRL  = 3'h1;
  localparam logic [2:0] MBD_CT_ASYNC = 3'h2;
  localparam logic [2:0] MBD_CT_ISOC  = 3'h3;
  // status bits
  localparam int MBD_ST_DONE = 0;
  localparam int MBD_ST_ERR  = 1;
  localparam int MBD_ST_W    = 2;
  // config fields
  localparam int MBD_CFG_EN_BIT   = 0;
  localparam int MBD_CFG_FPS_LSB  = 4;
  localparam logic [31:0] MBD_CFG_RST = 32'h0000_0000;
  // axi responses
  localparam logic [1:0] MBD_RESP_OKAY   = 2'h0;
  localparam logic [1:0] MBD_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    MBD_ENG_SCAN = 2'b01,
    MBD_ENG_BUSY = 2'b10
  } mbd_eng_t;
endpackage : mbd_pkg
`default_nettype wire

//--- verif/mbd_mem_model.sv
// Purpose: memory mover stand-in that answers block DMA page requests
// Assumes: a request is held until the one-cycle ack that ends it
// Notes:   err toggles outside an ack, so a stale value never looks valid
`default_nettype none
module mbd_mem_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       req_i,
  input  wire logic [3:0] lat_i,
  input  wire logic       fail_i,
  output logic            ack_o,
  output logic            err_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_r;
  // finish after lat_i waiting cycles; no new count while the ack is out
  wire logic  hit = req_i && !ack_o && cnt_r == lat_i;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {cnt_r, ack_o, err_o} <= '0;
    end else begin
      ack_o <= hit;
      err_o <= hit ? fail_i : ~err_o;
      cnt_r <= (req_i && !hit && !ack_o) ? cnt_r + 4'h1 : 4'h0;
    end
  end
endmodule : mbd_mem_model
`default_nettype wire

//--- verif/tb_media_bus_channel_dma_setup.sv
// Purpose: self-checking bench for the channel DMA setup block
// Assumes: memory mover model on the DMA side; the bench is the bus master
// Notes:   handshakes are sampled mid-cycle so no edge race decides them
`default_nettype none
module tb_media_bus_channel_dma_setup;
  import mbd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, rst_n_i, s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
  logic        s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o;
  logic        s_axi_rready_i, dma_req_o, dma_ack_i, dma_err_i, dma_mem_read_o, dma_pkt_start_o;
  logic        irq_o, fail_i, tx, ps;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, dma_addr_o, rd_q, pa, pb;
  logic [11:0] dma_len_o;
  logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
  logic [5:0]  dma_chan_o, ch;
  logic [3:0]  s_axi_wstrb_i, lat_i;
  logic [2:0]  dma_chan_type_o, frames_per_subbuf_o, fps, t;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, rs_q;
  integer      seed = 32'h53A8ACA4;
  int          n_mismatch, comparisons, i, pg;
  // handshake flags picked by index in wt; depths per type: 4x2x4, floor 5, field max, 2x188
  wire logic [5:0] hs = {!dma_req_o, s_axi_awready_o & s_axi_wready_o, dma_req_o,
                         s_axi_bvalid_o, s_axi_rvalid_o, s_axi_arready_o};
  logic [10:0] dep [4] = '{11'h01F, 11'h004, 11'h7FF, 11'h177};
  mbd_top dut_u (.*);
  mbd_mem_model mover_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(dma_req_o), .lat_i(lat_i),
                         .fail_i(fail_i), .ack_o(dma_ack_i), .err_o(dma_err_i));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic stop_test(input bit hung);
    n_mismatch += hung;
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // wait for flag k mid-cycle, then step to the edge that takes it; bounded
  task automatic wt(input int k);
    logic f = 1'b0;
    for (int j = 0; j < 400 && f !== 1'b1; j++) begin
      @(negedge clk_i);
      f = hs[k];
      rd_q = s_axi_rdata_o;
      rs_q = (k == 2) ? s_axi_bresp_o : s_axi_rresp_o;
      @(posedge clk_i);
    end
    if (f !== 1'b1) stop_test(1'b1);
  endtask : wt
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    {s_axi_awaddr_i, s_axi_wdata_i} <= {a, v};
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
    wt(4);
    {s_axi_awvalid_i, s_axi_wvalid_i} <= 2'h0;
    wt(2);
    s_axi_bready_i <= 1'b0;
    @(posedge clk_i);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    s_axi_araddr_i <= a;
    {s_axi_arvalid_i, s_axi_rready_i} <= 2'h3;
    wt(0);
    s_axi_arvalid_i <= 1'b0;
    wt(1);
    s_axi_rready_i <= 1'b0;
    @(posedge clk_i);
  endtask : rd
  // table words are only reachable through the address/data pair
  task automatic memory_iface(input logic [1:0] w, input logic [31:0] v);
    wr(MBD_MIF_ADDR_OFS, {24'h0, ch, w});
    wr(MBD_MIF_DATA_OFS, v);
  endtask : memory_iface
  function automatic logic [15:0] ent(input logic dir);
    return {4'h0, 1'b1, t == MBD_CT_SYNC, dir, t, ch};
  endfunction : ent
  // main sequence: config reset value, table clear, one channel per type through both pages
  initial begin
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i, lat_i, fail_i, rst_n_i} = '0;
    s_axi_wstrb_i = 4'hF;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    rd(MBD_CFG_OFS);
    chk(rd_q, MBD_CFG_RST);
    rd(8'h24);
    chk(32'(rs_q), 32'(MBD_RESP_SLVERR));
    // a write to a hole must be refused with an error response and change nothing
    wr(8'h24, 32'hFFFF_FFFF);
    chk(32'(rs_q), 32'(MBD_RESP_SLVERR));
    for (i = 0; i < 256; i++) begin
      wr(MBD_MIF_ADDR_OFS, 32'(i));
      wr(MBD_MIF_DATA_OFS, 32'h0);
    end
    for (t = 0; t < 4; t++) begin
      ch = (t == 0) ? 6'h00 : (t == 3) ? 6'h3F : 6'($random(seed));
      {tx, fps} = 4'($random(seed));
      pa = $random(seed) & 32'hFFFF_FFFC;
      pb = $random(seed) & 32'hFFFF_FFFC;
      ps = tx && (t == MBD_CT_CTRL || t == MBD_CT_ASYNC);
      lat_i <= 4'h2 + 4'($random(seed) & 7);
      fail_i <= (t == MBD_CT_ISOC);
      wr(MBD_TXMAP_LO_OFS, {32{tx}});
      wr(MBD_TXMAP_HI_OFS, {32{tx}});
      memory_iface(MBD_W_ALLOC, {ent(1'b1), ent(1'b0)});
      memory_iface(MBD_W_PING_BASE, pa);
      memory_iface(MBD_W_PONG_BASE, pb);
      memory_iface(MBD_W_CTRL, {1'b0, 1'b1, 3'h0, dep[t], 1'b0, 1'b1, 2'h0, ps, dep[t]});
      wr(MBD_CFG_OFS, {25'h0, fps, 4'h1});
      chk(32'(rs_q), 32'(MBD_RESP_OKAY));
      chk(32'(frames_per_subbuf_o), 32'(fps));
      for (pg = 0; pg < 2; pg++) begin
        wt(3);
        @(negedge clk_i);
        chk(dma_addr_o, (pg == 0) ? pa : pb);
        chk(32'(dma_len_o), 32'(dep[t]) + 32'h1);
        chk(32'({dma_mem_read_o, dma_pkt_start_o, dma_chan_type_o, dma_chan_o}),
            32'({tx, ps && pg == 0, t, ch}));
        wt(5);
      end
      chk(32'(irq_o), 32'h0);
      rd(MBD_MIF_DATA_OFS);
      chk(rd_q, {2'h0, fail_i, 1'b1, 1'b0, dep[t], 2'h0, fail_i, 1'b1, ps, dep[t]});
      rd(MBD_STATUS_OFS);
      // a failed page raises only the error event, a clean one only the done event
      chk(rd_q, {30'h0, fail_i, !fail_i});
      wr(MBD_IRQ_EN_OFS, 32'h3);
      chk(32'(irq_o), 32'h1);
      wr(MBD_IRQ_CLR_OFS, 32'h3);
      chk(32'(irq_o), 32'h0);
      wr(MBD_IRQ_EN_OFS, 32'h0);
      wr(MBD_CFG_OFS, 32'h0);
    end
    stop_test(1'b0);
  end
endmodule : tb_media_bus_channel_dma_setup
`default_nettype wire
